//--- design/gpc_config.sv
// Configuration register bank for the joystick port logical device.
// Assumes a classic Wishbone master on core_clk; pin-mux inputs are asynchronous.
module gpc_config (
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [9:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output      logic [31:0]             wb_dat_o,
    output      logic                    wb_ack_o,
    input  wire gpc_pkg::gpc_io_req_type ioReq,
    output      gpc_pkg::gpc_io_hit_type ioHit,
    output      logic                    enhancedMode,
    input  wire logic                    portFuncSelPin,
    input  wire logic                    pinSetSelPin,
    input  wire logic                    portDriveEn,
    output      logic                    portPinOutEn,
    output      logic [3:0]              pullupSetA,
    output      logic [3:0]              pullupSetB,
    output      logic                    deviceActive
);

    gpc_pkg::gpc_regs_type regs;
    gpc_pkg::gpc_regs_type next_regs;
    logic                  next_ack;
    logic [31:0]           next_datOut;
    logic [7:0]            readByte;
    logic [7:0]            index;
    logic                  wrStrobe;
    logic                  mapped;
    logic [1:0]            funcSync;
    logic [1:0]            setSync;
    logic [1:0]            next_funcSync;
    logic [1:0]            next_setSync;
    logic                  next_portPinOutEn;
    logic [3:0]            next_pullupSetA;
    logic [3:0]            next_pullupSetB;
    logic                  next_deviceActive;

    // Masked merge of write data into a byte
    function automatic logic [7:0] mergeBits(input logic [7:0] old, input logic [7:0] wdata,
                                             input logic [7:0] mask);
        mergeBits = (old & ~mask) | (wdata & mask);
    endfunction : mergeBits

    function automatic logic isMapped(input logic [7:0] idx);
        isMapped = (idx == gpc_pkg::IDX_LD_ACTIVATE) || (idx == gpc_pkg::IDX_BASE_ADDR_HIGH)
                || (idx == gpc_pkg::IDX_BASE_ADDR_LOW) || (idx == gpc_pkg::IDX_IRQ_SELECT_WAKE)
                || (idx == gpc_pkg::IDX_IRQ_KIND) || (idx == gpc_pkg::IDX_DMA_REPORT_FIRST)
                || (idx == gpc_pkg::IDX_DMA_REPORT_SECOND) || (idx == gpc_pkg::IDX_JOYSTICK_PORT_CONFIG);
    endfunction : isMapped

    // Bus slave: ack one cycle after request, write lands on the acked edge
    always_comb begin
        index    = wb_adr_i[9:2];
        mapped   = isMapped(index) && (wb_adr_i[1:0] == gpc_pkg::WB_ALIGN);
        wrStrobe = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && mapped;
        next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
        unique case (index)
            gpc_pkg::IDX_LD_ACTIVATE:          readByte = regs.ldActivate;
            gpc_pkg::IDX_BASE_ADDR_HIGH:       readByte = regs.baseAddrHigh;
            gpc_pkg::IDX_BASE_ADDR_LOW:        readByte = regs.baseAddrLow;
            gpc_pkg::IDX_IRQ_SELECT_WAKE:      readByte = regs.irqSelectWake;
            gpc_pkg::IDX_IRQ_KIND:             readByte = regs.irqKind;
            gpc_pkg::IDX_DMA_REPORT_FIRST:     readByte = gpc_pkg::VAL_DMA_REPORT;
            gpc_pkg::IDX_DMA_REPORT_SECOND:    readByte = gpc_pkg::VAL_DMA_REPORT;
            gpc_pkg::IDX_JOYSTICK_PORT_CONFIG: readByte = regs.joystickPortConfig;
            default:                           readByte = 8'h00;
        endcase
        if (!mapped) begin
            readByte = 8'h00;
        end
        next_datOut = (next_ack && !wb_we_i) ? {24'h000000, readByte} : 32'h00000000;
    end

    always_comb begin
        next_regs = regs;
        if (wrStrobe) begin
            unique case (index)
                gpc_pkg::IDX_LD_ACTIVATE:     next_regs.ldActivate = wb_dat_i[7:0];
                gpc_pkg::IDX_BASE_ADDR_HIGH:  next_regs.baseAddrHigh = wb_dat_i[7:0];
                gpc_pkg::IDX_BASE_ADDR_LOW:   next_regs.baseAddrLow = wb_dat_i[7:0];
                gpc_pkg::IDX_IRQ_SELECT_WAKE: next_regs.irqSelectWake = wb_dat_i[7:0];
                gpc_pkg::IDX_IRQ_KIND:
                    next_regs.irqKind = mergeBits(regs.irqKind, wb_dat_i[7:0], gpc_pkg::MASK_IRQ_KIND_RW);
                gpc_pkg::IDX_JOYSTICK_PORT_CONFIG:
                    next_regs.joystickPortConfig = wb_dat_i[7:0] & gpc_pkg::MASK_CFG_RW;
                default:                      next_regs = regs;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            regs.ldActivate         <= gpc_pkg::RST_LD_ACTIVATE;
            regs.baseAddrHigh       <= gpc_pkg::RST_BASE_ADDR_HIGH;
            regs.baseAddrLow        <= gpc_pkg::RST_BASE_ADDR_LOW;
            regs.irqSelectWake      <= gpc_pkg::RST_IRQ_SELECT_WAKE;
            regs.irqKind            <= gpc_pkg::RST_IRQ_KIND;
            regs.joystickPortConfig <= gpc_pkg::RST_JOYSTICK_PORT_CONFIG;
            wb_ack_o                <= 1'b0;
            wb_dat_o                <= 32'h00000000;
        end else begin
            regs     <= next_regs;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_datOut;
        end
    end

    // Pin controls; pin-mux selects are asynchronous so synchronised first
    always_comb begin
        next_funcSync     = {funcSync[0], portFuncSelPin};
        next_setSync      = {setSync[0], pinSetSelPin};
        next_deviceActive = regs.ldActivate[gpc_pkg::BIT_ACTIVATE];
        next_portPinOutEn = portDriveEn
                            && !(regs.joystickPortConfig[gpc_pkg::BIT_CFG_TRISTATE] && !next_deviceActive);
        next_pullupSetA   = {4{regs.joystickPortConfig[gpc_pkg::BIT_CFG_PULLUP] && funcSync[1] && !setSync[1]}};
        next_pullupSetB   = {4{regs.joystickPortConfig[gpc_pkg::BIT_CFG_PULLUP] && funcSync[1] && setSync[1]}};
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            funcSync     <= 2'h0;
            setSync      <= 2'h0;
            deviceActive <= 1'b0;
            portPinOutEn <= 1'b0;
            pullupSetA   <= 4'h0;
            pullupSetB   <= 4'h0;
        end else begin
            funcSync     <= next_funcSync;
            setSync      <= next_setSync;
            deviceActive <= next_deviceActive;
            portPinOutEn <= next_portPinOutEn;
            pullupSetA   <= next_pullupSetA;
            pullupSetB   <= next_pullupSetB;
        end
    end

    gpc_io_decode u_decode (
        .core_clk     (core_clk),
        .nrst         (nrst),
        .ioReq        (ioReq),
        .baseAddr     ({regs.baseAddrHigh, regs.baseAddrLow}),
        .enhancedBit  (regs.joystickPortConfig[gpc_pkg::BIT_CFG_ENHANCED]),
        .active       (regs.ldActivate[gpc_pkg::BIT_ACTIVATE]),
        .ioHit        (ioHit),
        .enhancedMode (enhancedMode)
    );

    // Assertions
    a_inactive_block: assert property (@(posedge core_clk) disable iff (!nrst)
        !regs.ldActivate[gpc_pkg::BIT_ACTIVATE] |=> !ioHit.hit)
        else $error("Hit while device inactive");

    a_base_reset: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(nrst) |-> {regs.baseAddrHigh, regs.baseAddrLow} == 16'h0201)
        else $error("Base address reset value wrong");

    a_base_write: assert property (@(posedge core_clk) disable iff (!nrst)
        wrStrobe && index == gpc_pkg::IDX_BASE_ADDR_LOW |=> regs.baseAddrLow == $past(wb_dat_i[7:0]))
        else $error("Base address low not written");

    a_kind_fixed: assert property (@(posedge core_clk) disable iff (!nrst)
        (regs.irqKind & ~gpc_pkg::MASK_IRQ_KIND_RW) == 8'h01)
        else $error("Interrupt kind fixed bits changed");

    a_dma_fixed: assert property (@(posedge core_clk) disable iff (!nrst)
        next_ack && !wb_we_i && (index == gpc_pkg::IDX_DMA_REPORT_FIRST || index == gpc_pkg::IDX_DMA_REPORT_SECOND)
        && mapped |=> wb_ack_o && wb_dat_o == 32'h00000004)
        else $error("DMA report not 04h");

    a_sel_write: assert property (@(posedge core_clk) disable iff (!nrst)
        wrStrobe && index == gpc_pkg::IDX_IRQ_SELECT_WAKE |=> regs.irqSelectWake == $past(wb_dat_i[7:0]))
        else $error("Interrupt select not written");

    a_cfg_reserved: assert property (@(posedge core_clk) disable iff (!nrst)
        (regs.joystickPortConfig & ~gpc_pkg::MASK_CFG_RW) == 8'h00)
        else $error("Reserved configuration bits set");

    a_float_pins: assert property (@(posedge core_clk) disable iff (!nrst)
        regs.joystickPortConfig[0] && !regs.ldActivate[0] |=> !portPinOutEn)
        else $error("Outputs driven while floated");

    a_pullup_off: assert property (@(posedge core_clk) disable iff (!nrst)
        !regs.joystickPortConfig[2] |=> pullupSetA == 4'h0 && pullupSetB == 4'h0)
        else $error("Pull-up on while disabled");

    a_force_legacy: assert property (@(posedge core_clk) disable iff (!nrst)
        regs.baseAddrLow[3:0] != 4'h0 |=> !enhancedMode)
        else $error("Enhanced mode with unaligned base");

    a_enter_enh: assert property (@(posedge core_clk) disable iff (!nrst)
        regs.baseAddrLow[3:0] == 4'h0 && regs.joystickPortConfig[3] |=> enhancedMode)
        else $error("Enhanced mode not entered");

    a_legacy_exact: assert property (@(posedge core_clk) disable iff (!nrst)
        ioHit.hit && ioHit.legacy |-> $past(ioReq.addr) == $past({regs.baseAddrHigh, regs.baseAddrLow})
        && ioHit.regSel == 4'h0)
        else $error("Legacy hit off base address");

    a_ack_pulse: assert property (@(posedge core_clk) disable iff (!nrst)
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack longer than one cycle");

    a_kind_write: assert property (@(posedge core_clk) disable iff (!nrst)
        wrStrobe && index == gpc_pkg::IDX_IRQ_KIND |=> regs.irqKind[1] == $past(wb_dat_i[1]))
        else $error("Interrupt kind bit 1 not written");

    a_cfg_write: assert property (@(posedge core_clk) disable iff (!nrst)
        wrStrobe && index == gpc_pkg::IDX_JOYSTICK_PORT_CONFIG
        |=> regs.joystickPortConfig == ($past(wb_dat_i[7:0]) & 8'h0D))
        else $error("Configuration byte write wrong");

    a_out_follow: assert property (@(posedge core_clk) disable iff (!nrst)
        !regs.joystickPortConfig[0] |=> portPinOutEn == $past(portDriveEn))
        else $error("Output enable not following drive");

    a_pullup_on: assert property (@(posedge core_clk) disable iff (!nrst)
        regs.joystickPortConfig[2] && funcSync[1] |=> (pullupSetA ^ pullupSetB) == 4'hF)
        else $error("Pull-ups not on exactly one pin set");

    a_lane_off: assert property (@(posedge core_clk) disable iff (!nrst)
        wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && !wb_sel_i[0] |=> regs == $past(regs))
        else $error("Write landed with byte 0 disabled");

    a_active_flag: assert property (@(posedge core_clk) disable iff (!nrst)
        deviceActive == $past(regs.ldActivate[0]))
        else $error("Active flag not following register");

    c_cfg_write: cover property (@(posedge core_clk) disable iff (!nrst)
        wrStrobe && index == gpc_pkg::IDX_JOYSTICK_PORT_CONFIG);
    c_enh_hit: cover property (@(posedge core_clk) disable iff (!nrst)
        ioHit.hit && !ioHit.legacy);
    c_legacy_hit: cover property (@(posedge core_clk) disable iff (!nrst)
        ioHit.hit && ioHit.legacy);
    c_floated: cover property (@(posedge core_clk) disable iff (!nrst)
        portDriveEn && !portPinOutEn);

endmodule : gpc_config

//--- design/gpc_pkg.sv
// Constants, field layouts and carrier types for the joystick port configuration bank.
// Assumes an 8-bit configuration index space reached as word-aligned Wishbone registers.
// What this block does
// - Inactive device blocks all functional register access
// - Base address resets 02h/01h, read/write
// - Interrupt kind: only bit 1 writable, reset 03h
// - Both DMA reports read-only, always 04h
// - Interrupt select and wake read/write, reset zero
// - Hardware reset clears the port configuration byte
// - Configuration bit 3 requests enhanced mode
// - Bit 2 enables button pull-ups, active set
// - Bit 0 with inactive device floats outputs
// - Legacy mode decodes only status at base
// - Unaligned base address forces legacy mode
// - Enhanced needs bit 3 and 16-byte alignment
package gpc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_LD_ACTIVATE          = 8'h30;
    localparam logic [7:0] IDX_BASE_ADDR_HIGH       = 8'h60;
    localparam logic [7:0] IDX_BASE_ADDR_LOW        = 8'h61;
    localparam logic [7:0] IDX_IRQ_SELECT_WAKE      = 8'h70;
    localparam logic [7:0] IDX_IRQ_KIND             = 8'h71;
    localparam logic [7:0] IDX_DMA_REPORT_FIRST     = 8'h74;
    localparam logic [7:0] IDX_DMA_REPORT_SECOND    = 8'h75;
    localparam logic [7:0] IDX_JOYSTICK_PORT_CONFIG = 8'hF0;

    // Reset values
    localparam logic [7:0] RST_LD_ACTIVATE          = 8'h00;
    localparam logic [7:0] RST_BASE_ADDR_HIGH       = 8'h02;
    localparam logic [7:0] RST_BASE_ADDR_LOW        = 8'h01;
    localparam logic [7:0] RST_IRQ_SELECT_WAKE      = 8'h00;
    localparam logic [7:0] RST_IRQ_KIND             = 8'h03;
    localparam logic [7:0] VAL_DMA_REPORT           = 8'h04;
    localparam logic [7:0] RST_JOYSTICK_PORT_CONFIG = 8'h00;

    // Field positions and masks
    localparam int         BIT_ACTIVATE     = 0;
    localparam int         BIT_IRQ_KIND_RW  = 1;
    localparam int         BIT_CFG_TRISTATE = 0;
    localparam int         BIT_CFG_PULLUP   = 2;
    localparam int         BIT_CFG_ENHANCED = 3;
    localparam logic [7:0] MASK_IRQ_KIND_RW = 8'h02;
    localparam logic [7:0] MASK_CFG_RW      = 8'h0D;
    localparam logic [3:0] ALIGN_ZERO       = 4'h0;
    localparam logic [3:0] LEGACY_REG_SEL   = 4'h0;

    // Wishbone geometry
    localparam int         WB_ADR_W  = 10;
    localparam logic [1:0] WB_ALIGN  = 2'h0;

    typedef struct packed {
        logic [7:0] ldActivate;
        logic [7:0] baseAddrHigh;
        logic [7:0] baseAddrLow;
        logic [7:0] irqSelectWake;
        logic [7:0] irqKind;
        logic [7:0] joystickPortConfig;
    } gpc_regs_type;

    typedef struct packed {
        logic        req;
        logic [15:0] addr;
    } gpc_io_req_type;

    typedef struct packed {
        logic       hit;
        logic       legacy;
        logic [3:0] regSel;
    } gpc_io_hit_type;

endpackage : gpc_pkg

//--- design/gpc_io_decode.sv
// Functional address decoder for the joystick port.
// Assumes the I/O request comes from logic on core_clk; one cycle registered answer.
module gpc_io_decode (
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    input  wire gpc_pkg::gpc_io_req_type ioReq,
    input  wire logic [15:0]             baseAddr,
    input  wire logic                    enhancedBit,
    input  wire logic                    active,
    output      gpc_pkg::gpc_io_hit_type ioHit,
    output      logic                    enhancedMode
);

    gpc_pkg::gpc_io_hit_type next_ioHit;
    logic                    next_enhancedMode;
    logic                    aligned;

    always_comb begin
        aligned = (baseAddr[3:0] == gpc_pkg::ALIGN_ZERO);
        next_enhancedMode = enhancedBit && aligned;
        next_ioHit        = '0;
        next_ioHit.legacy = !next_enhancedMode;
        if (ioReq.req && active) begin
            if (next_enhancedMode) begin
                next_ioHit.hit    = (ioReq.addr[15:4] == baseAddr[15:4]);
                next_ioHit.regSel = ioReq.addr[3:0];
            end else begin
                next_ioHit.hit    = (ioReq.addr == baseAddr);
                next_ioHit.regSel = gpc_pkg::LEGACY_REG_SEL;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ioHit        <= '0;
            enhancedMode <= 1'b0;
        end else begin
            ioHit        <= next_ioHit;
            enhancedMode <= next_enhancedMode;
        end
    end

endmodule : gpc_io_decode

//--- verification/game_port_config_test.sv
// Self-checking bench for the joystick port configuration bank.
// Assumes gpc_config as the top; the bench drives every input itself.
module game_port_config_test;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int TIMEOUT_CYCLES = 4000;

    logic                    core_clk;
    logic                    nrst;
    logic                    wb_cyc_i;
    logic                    wb_stb_i;
    logic                    wb_we_i;
    logic [9:0]              wb_adr_i;
    logic [3:0]              wb_sel_i;
    logic [31:0]             wb_dat_i;
    logic [31:0]             wb_dat_o;
    logic                    wb_ack_o;
    gpc_pkg::gpc_io_req_type ioReq;
    gpc_pkg::gpc_io_hit_type ioHit;
    logic                    enhancedMode;
    logic                    portFuncSelPin;
    logic                    pinSetSelPin;
    logic                    portDriveEn;
    logic                    portPinOutEn;
    logic [3:0]              pullupSetA;
    logic [3:0]              pullupSetB;
    logic                    deviceActive;
    int                      nMismatch;
    int                      samplesChecked;
    int                      cycleCount;

    gpc_config dut_u (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ioReq(ioReq), .ioHit(ioHit),
        .enhancedMode(enhancedMode), .portFuncSelPin(portFuncSelPin), .pinSetSelPin(pinSetSelPin),
        .portDriveEn(portDriveEn), .portPinOutEn(portPinOutEn), .pullupSetA(pullupSetA),
        .pullupSetB(pullupSetB), .deviceActive(deviceActive));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Holds the request until ack is seen; only the global timeout ends a hung wait
    task automatic wb_xfer(input logic we, input logic [9:0] adr, input logic [7:0] data,
                           input logic [3:0] sel, output logic [31:0] rdata);
        int waitN;
        waitN = 0;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h000000, data};
        do begin
            @(posedge core_clk);
            waitN++;
        end while (wb_ack_o !== 1'b1);
        rdata = wb_dat_o;
        // Ack one cycle after the taking edge
        check(waitN, 32'h00000002);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        logic [31:0] unused;
        wb_xfer(1'b1, {idx, 2'h0}, data, 4'hF, unused);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        wb_xfer(1'b0, {idx, 2'h0}, 8'h00, 4'hF, r);
        check(r, {24'h000000, exp});
    endtask : rd_chk

    // Misses compare the hit flag only; legacy still shows the mode and regSel may be nonzero then
    task automatic probe(input logic [15:0] a, input logic hit, input logic leg, input logic [3:0] sel);
        @(posedge core_clk);
        ioReq <= '{req: 1'b1, addr: a};
        @(posedge core_clk);
        ioReq <= '{req: 1'b0, addr: 16'h0000};
        @(posedge core_clk);
        if (hit) check({26'h0, ioHit}, {26'h0, hit, leg, sel});
        else check({31'h0, ioHit.hit}, 32'h0);
    endtask : probe

    task automatic pulse_reset();
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
    endtask : pulse_reset

    task automatic t_reset_values();
        rd_chk(gpc_pkg::IDX_LD_ACTIVATE, 8'h00);
        rd_chk(gpc_pkg::IDX_BASE_ADDR_HIGH, 8'h02);
        rd_chk(gpc_pkg::IDX_BASE_ADDR_LOW, 8'h01);
        rd_chk(gpc_pkg::IDX_IRQ_SELECT_WAKE, 8'h00);
        rd_chk(gpc_pkg::IDX_IRQ_KIND, 8'h03);
        rd_chk(gpc_pkg::IDX_DMA_REPORT_FIRST, 8'h04);
        rd_chk(gpc_pkg::IDX_DMA_REPORT_SECOND, 8'h04);
        rd_chk(gpc_pkg::IDX_JOYSTICK_PORT_CONFIG, 8'h00);
        rd_chk(8'h3F, 8'h00);
        $display("test reset_values finished");
    endtask : t_reset_values

    task automatic t_reg_access();
        logic [31:0] unused;
        wr(gpc_pkg::IDX_BASE_ADDR_HIGH, 8'hFF);
        rd_chk(gpc_pkg::IDX_BASE_ADDR_HIGH, 8'hFF);
        wr(gpc_pkg::IDX_BASE_ADDR_LOW, 8'hA5);
        rd_chk(gpc_pkg::IDX_BASE_ADDR_LOW, 8'hA5);
        wr(gpc_pkg::IDX_IRQ_SELECT_WAKE, 8'h5A);
        rd_chk(gpc_pkg::IDX_IRQ_SELECT_WAKE, 8'h5A);
        wr(gpc_pkg::IDX_IRQ_KIND, 8'hFF);
        rd_chk(gpc_pkg::IDX_IRQ_KIND, 8'h03);
        wr(gpc_pkg::IDX_IRQ_KIND, 8'h00);
        rd_chk(gpc_pkg::IDX_IRQ_KIND, 8'h01);
        wr(gpc_pkg::IDX_DMA_REPORT_FIRST, 8'h00);
        wr(gpc_pkg::IDX_DMA_REPORT_SECOND, 8'hFF);
        rd_chk(gpc_pkg::IDX_DMA_REPORT_FIRST, 8'h04);
        rd_chk(gpc_pkg::IDX_DMA_REPORT_SECOND, 8'h04);
        wr(gpc_pkg::IDX_JOYSTICK_PORT_CONFIG, 8'hFF);
        rd_chk(gpc_pkg::IDX_JOYSTICK_PORT_CONFIG, 8'h0D);
        wb_xfer(1'b1, {gpc_pkg::IDX_JOYSTICK_PORT_CONFIG, 2'h0}, 8'h00, 4'h0, unused);
        rd_chk(gpc_pkg::IDX_JOYSTICK_PORT_CONFIG, 8'h0D);
        // Misaligned byte address is acked but refused
        wb_xfer(1'b1, {gpc_pkg::IDX_JOYSTICK_PORT_CONFIG, 2'h1}, 8'h00, 4'hF, unused);
        rd_chk(gpc_pkg::IDX_JOYSTICK_PORT_CONFIG, 8'h0D);
        wb_xfer(1'b0, {gpc_pkg::IDX_BASE_ADDR_HIGH, 2'h2}, 8'h00, 4'hF, unused);
        check(unused, 32'h00000000);
        wr(8'h3F, 8'hFF);
        rd_chk(8'h3F, 8'h00);
        pulse_reset();
        rd_chk(gpc_pkg::IDX_JOYSTICK_PORT_CONFIG, 8'h00);
        rd_chk(gpc_pkg::IDX_BASE_ADDR_HIGH, 8'h02);
        rd_chk(gpc_pkg::IDX_IRQ_KIND, 8'h03);
        $display("test reg_access finished");
    endtask : t_reg_access

    task automatic t_decode();
        probe(16'h0201, 1'b0, 1'b0, 4'h0);
        wr(gpc_pkg::IDX_LD_ACTIVATE, 8'h01);
        // Register lands at the ack edge, the flag one edge later
        repeat (2) @(posedge core_clk);
        check({31'h0, deviceActive}, 32'h1);
        probe(16'h0201, 1'b1, 1'b1, 4'h0);
        probe(16'h0200, 1'b0, 1'b0, 4'h0);
        wr(gpc_pkg::IDX_JOYSTICK_PORT_CONFIG, 8'h08);
        repeat (2) @(posedge core_clk);
        check({31'h0, enhancedMode}, 32'h0);
        probe(16'h0202, 1'b0, 1'b0, 4'h0);
        wr(gpc_pkg::IDX_BASE_ADDR_LOW, 8'h00);
        repeat (2) @(posedge core_clk);
        check({31'h0, enhancedMode}, 32'h1);
        probe(16'h0205, 1'b1, 1'b0, 4'h5);
        probe(16'h020F, 1'b1, 1'b0, 4'hF);
        probe(16'h0210, 1'b0, 1'b0, 4'h0);
        wr(gpc_pkg::IDX_JOYSTICK_PORT_CONFIG, 8'h00);
        repeat (2) @(posedge core_clk);
        check({31'h0, enhancedMode}, 32'h0);
        probe(16'h0205, 1'b0, 1'b0, 4'h0);
        probe(16'h0200, 1'b1, 1'b1, 4'h0);
        wr(gpc_pkg::IDX_LD_ACTIVATE, 8'h00);
        probe(16'h0200, 1'b0, 1'b0, 4'h0);
        $display("test decode finished");
    endtask : t_decode

    // Sync stages on the pin inputs need a few edges before outputs follow
    task automatic t_pins();
        wr(gpc_pkg::IDX_JOYSTICK_PORT_CONFIG, 8'h01);
        repeat (3) @(posedge core_clk);
        check({31'h0, portPinOutEn}, 32'h0);
        wr(gpc_pkg::IDX_JOYSTICK_PORT_CONFIG, 8'h00);
        repeat (3) @(posedge core_clk);
        check({31'h0, portPinOutEn}, 32'h1);
        wr(gpc_pkg::IDX_JOYSTICK_PORT_CONFIG, 8'h01);
        wr(gpc_pkg::IDX_LD_ACTIVATE, 8'h01);
        repeat (3) @(posedge core_clk);
        check({31'h0, portPinOutEn}, 32'h1);
        portFuncSelPin <= 1'b1;
        wr(gpc_pkg::IDX_JOYSTICK_PORT_CONFIG, 8'h04);
        repeat (5) @(posedge core_clk);
        check({24'h0, pullupSetA, pullupSetB}, 32'hF0);
        pinSetSelPin <= 1'b1;
        repeat (5) @(posedge core_clk);
        check({24'h0, pullupSetA, pullupSetB}, 32'h0F);
        portFuncSelPin <= 1'b0;
        repeat (5) @(posedge core_clk);
        check({24'h0, pullupSetA, pullupSetB}, 32'h00);
        portDriveEn <= 1'b0;
        repeat (3) @(posedge core_clk);
        check({31'h0, portPinOutEn}, 32'h0);
        portDriveEn <= 1'b1;
        repeat (3) @(posedge core_clk);
        check({31'h0, portPinOutEn}, 32'h1);
        $display("test pins finished");
    endtask : t_pins

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    always @(posedge core_clk) begin
        cycleCount++;
        if (cycleCount >= TIMEOUT_CYCLES) begin
            nMismatch++;
            end_of_test();
        end
    end

    initial begin
        nMismatch = 0;
        samplesChecked = 0;
        cycleCount = 0;
        nrst = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 10'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
        ioReq = '{req: 1'b0, addr: 16'h0000};
        portFuncSelPin = 1'b0;
        pinSetSelPin = 1'b0;
        portDriveEn = 1'b1;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset_values();
        t_reg_access();
        t_decode();
        t_pins();
        end_of_test();
    end
endmodule : game_port_config_test
